// [phy_interrupt_management_bench.sv]
`default_nettype none
module phy_interrupt_management_bench
  import pim_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PULSE = 20;
  logic        mclk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        an_restart_i = 1'b0;
  logic [7:0]  src = 8'h80;
  logic [4:0]  addr;
  logic        rd, wr, alt, irq_n;
  logic [15:0] wdata, rdata, d;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #5 mclk_i = ~mclk_i;

  pim_irq_ctrl #(.ENERGY_PULSE_CYCLES(PULSE)) pim_irq_ctrl_inst (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .line_energy_present_i(src[7]), .an_complete_i(src[6]), .remote_fault_i(src[5]),
    .link_status_i(~src[4]), .lp_ack_i(src[3]), .par_fault_i(src[2]),
    .page_rx_i(src[1]), .an_restart_i(an_restart_i),
    .alt_irq_scheme_sel_o(alt), .irq_out_low_o(irq_n));

  pim_host_model pim_host_model_inst (
    .mclk_i(mclk_i), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata),
    .rdata_i(rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : step

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    pim_host_model_inst.rd_reg(a, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic set_src(input int i, input logic v);
    @(posedge mclk_i);
    src[i] <= v;
    step(3);
  endtask : set_src

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    rd_chk(ADDR_IRQ_FLAGS, 16'h0080);
    rd_chk(ADDR_IRQ_MASK, 16'h0000);
    rd_chk(ADDR_MODE_CTRL, 16'h0000);
    chk({15'h0, alt}, 16'h0000);
    set_src(7, 1'b0);
    pim_host_model_inst.wr_reg(ADDR_IRQ_MASK, 16'hFFFF);
    rd_chk(ADDR_IRQ_MASK, 16'h00FE);
    chk({15'h0, irq_n}, 16'h0001);
    $display("reset and mask test done");

    // primary: assert on event, release on opposite edge, except link down, which releases only on a read
    for (int i = 1; i < 8; i++) begin
      if (i != 4) begin
        set_src(i, 1'b1);
        chk({15'h0, irq_n}, 16'h0000);
        set_src(i, 1'b0);
        chk({15'h0, irq_n}, 16'h0001);
      end
    end
    set_src(4, 1'b1);
    set_src(4, 1'b0);
    chk({15'h0, irq_n}, 16'h0000);
    rd_chk(ADDR_IRQ_FLAGS, 16'h0010);
    step(1);
    chk({15'h0, irq_n}, 16'h0001);
    set_src(5, 1'b1);
    chk({15'h0, irq_n}, 16'h0000);
    // flag writes do nothing in the primary scheme
    pim_host_model_inst.wr_reg(ADDR_IRQ_FLAGS, 16'h0020);
    step(1);
    chk({15'h0, irq_n}, 16'h0000);
    rd_chk(ADDR_BASIC_STATUS, 16'h0000);
    step(1);
    chk({15'h0, irq_n}, 16'h0001);
    set_src(2, 1'b1);
    chk({15'h0, irq_n}, 16'h0000);
    rd_chk(ADDR_AN_EXPANSION, 16'h0000);
    step(1);
    chk({15'h0, irq_n}, 16'h0001);
    set_src(1, 1'b1);
    chk({15'h0, irq_n}, 16'h0000);
    @(posedge mclk_i);
    an_restart_i <= 1'b1;
    @(posedge mclk_i);
    an_restart_i <= 1'b0;
    step(2);
    chk({15'h0, irq_n}, 16'h0001);
    set_src(1, 1'b0);
    set_src(1, 1'b1);
    set_src(4, 1'b1);
    rd_chk(ADDR_IRQ_FLAGS, 16'h0010);
    set_src(4, 1'b0);
    @(posedge mclk_i);
    src <= 8'h00;
    step(3);
    $display("primary test done");

    // energy released while present, then cable pulled
    set_src(7, 1'b1);
    rd_chk(ADDR_IRQ_FLAGS, 16'h0080);
    step(1);
    chk({15'h0, irq_n}, 16'h0001);
    set_src(7, 1'b0);
    step(1);
    chk({15'h0, irq_n}, 16'h0000);
    step(PULSE - 3);
    chk({15'h0, irq_n}, 16'h0000);
    step(1);
    chk({15'h0, irq_n}, 16'h0001);
    pim_host_model_inst.wr_reg(ADDR_IRQ_MASK, 16'h007E);
    $display("energy pulse test done");

    // alternate scheme
    pim_host_model_inst.wr_reg(ADDR_MODE_CTRL, 16'h0040);
    rd_chk(ADDR_MODE_CTRL, 16'h0040);
    chk({15'h0, alt}, 16'h0001);
    set_src(6, 1'b1);
    chk({15'h0, irq_n}, 16'h0000);
    pim_host_model_inst.wr_reg(ADDR_IRQ_FLAGS, 16'h0040);
    step(1);
    chk({15'h0, irq_n}, 16'h0000);
    set_src(6, 1'b0);
    rd_chk(ADDR_IRQ_FLAGS, 16'h0040);
    pim_host_model_inst.wr_reg(ADDR_IRQ_FLAGS, 16'h0040);
    step(1);
    chk({15'h0, irq_n}, 16'h0001);
    // energy flag latches although masked out; recheck keeps it while energy stays
    set_src(7, 1'b1);
    pim_host_model_inst.wr_reg(ADDR_IRQ_FLAGS, 16'h0080);
    rd_chk(ADDR_IRQ_FLAGS, 16'h0080);
    set_src(7, 1'b0);
    pim_host_model_inst.wr_reg(ADDR_IRQ_FLAGS, 16'h0080);
    rd_chk(ADDR_IRQ_FLAGS, 16'h0000);
    set_src(4, 1'b1);
    set_src(4, 1'b0);
    chk({15'h0, irq_n}, 16'h0000);
    pim_host_model_inst.wr_reg(ADDR_IRQ_FLAGS, 16'h0010);
    step(1);
    chk({15'h0, irq_n}, 16'h0001);
    set_src(3, 1'b1);
    chk({15'h0, irq_n}, 16'h0000);
    pim_host_model_inst.wr_reg(ADDR_IRQ_MASK, 16'h0076);
    step(1);
    chk({15'h0, irq_n}, 16'h0001);
    $display("alternate test done");

    @(posedge mclk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    step(1);
    chk({15'h0, alt}, 16'h0000);
    chk({15'h0, irq_n}, 16'h0001);
    rd_chk(ADDR_IRQ_MASK, 16'h0000);
    rd_chk(ADDR_MODE_CTRL, 16'h0000);
    $display("second reset test done");
    end_of_test();
  end
endmodule : phy_interrupt_management_bench
`default_nettype wire

// [pim_host_model.sv]
`default_nettype none
module pim_host_model
  import pim_pkg::*;
(
  input  wire logic                  mclk_i,
  output logic      [REG_ADDR_W-1:0] addr_o,
  output logic                       rd_o,
  output logic                       wr_o,
  output logic      [REG_DATA_W-1:0] wdata_o,
  input  wire logic [REG_DATA_W-1:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr_o  = '0;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = '0;
  end

  // released lines show the inverse of the last value, so a stale value never reads as valid
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge mclk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge mclk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(negedge mclk_i);
    d = rdata_i;
  endtask : rd_reg
endmodule : pim_host_model
`default_nettype wire

// [pim_irq_ctrl.sv]
`default_nettype none
module pim_irq_ctrl
  import pim_pkg::*;
#(
  parameter int ENERGY_PULSE_CYCLES = ENERGY_PULSE_CYC
) (
  input  wire logic                  mclk_i,
  input  wire logic                  resetn_i,
  input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic                  reg_wr_i,
  input  wire logic [REG_DATA_W-1:0] reg_wdata_i,
  output logic      [REG_DATA_W-1:0] reg_rdata_o,
  input  wire logic                  line_energy_present_i,
  input  wire logic                  an_complete_i,
  input  wire logic                  remote_fault_i,
  input  wire logic                  link_status_i,
  input  wire logic                  lp_ack_i,
  input  wire logic                  par_fault_i,
  input  wire logic                  page_rx_i,
  input  wire logic                  an_restart_i,
  output logic                       alt_irq_scheme_sel_o,
  output logic                       irq_out_low_o
);
  logic [15:0] flags_reg;
  logic [15:0] flags_next;
  logic [15:0] mask_reg;
  logic [15:0] mask_next;
  logic        alt_next;
  logic [7:0]  act_prev_reg;
  logic        armed_reg;
  logic        armed_next;
  logic        irq_next;
  logic [15:0] rdata_next;
  logic [7:0]  act;
  logic [7:0]  set_ev;
  logic [7:0]  fall_ev;
  logic [7:0]  clr;
  logic        rd_flags;
  logic        rd_status;
  logic        rd_expan;
  logic        pulse_start;
  logic        pulse_abort;
  logic        pulse_busy;

  function automatic logic hit(input logic strobe, input logic [4:0] addr,
                               input logic [4:0] want);
    hit = strobe && (addr == want);
  endfunction : hit

  // link source is active when the link is down
  assign act = {line_energy_present_i, an_complete_i, remote_fault_i, ~link_status_i,
                lp_ack_i, par_fault_i, page_rx_i, 1'b0};
  assign set_ev   = act & ~act_prev_reg;
  assign fall_ev  = ~act & act_prev_reg;
  assign rd_flags  = hit(reg_rd_i, reg_addr_i, ADDR_IRQ_FLAGS);
  assign rd_status = hit(reg_rd_i, reg_addr_i, ADDR_BASIC_STATUS);
  assign rd_expan  = hit(reg_rd_i, reg_addr_i, ADDR_AN_EXPANSION);

  always_comb begin
    clr = 8'h00;
    if (!alt_irq_scheme_sel_o) begin
      clr = fall_ev;
      clr[SRC_LINK_DOWN] = 1'b0;
      if (rd_flags) begin
        clr = 8'hFE;
      end
      if (rd_status) begin
        clr[SRC_REM_FAULT] = 1'b1;
        clr[SRC_LINK_DOWN] = 1'b1;
      end
      if (rd_expan || an_restart_i || set_ev[SRC_LINK_DOWN]) begin
        clr[SRC_PAR_FAULT] = 1'b1;
        clr[SRC_PAGE_RX]   = 1'b1;
      end
    end else if (hit(reg_wr_i, reg_addr_i, ADDR_IRQ_FLAGS)) begin
      // recheck only sources whose release condition holds now
      clr = reg_wdata_i[7:0] & ~act;
    end
    clr = clr & SRC_VALID_MASK[7:0];
  end

  always_comb begin
    // a new event in the same cycle as a clear keeps the flag set
    flags_next = (flags_reg & ~{8'h00, clr}) | {8'h00, set_ev};
    flags_next = flags_next & SRC_VALID_MASK;
    mask_next  = mask_reg;
    alt_next   = alt_irq_scheme_sel_o;
    if (hit(reg_wr_i, reg_addr_i, ADDR_IRQ_MASK)) begin
      mask_next = reg_wdata_i & SRC_VALID_MASK;
    end
    if (hit(reg_wr_i, reg_addr_i, ADDR_MODE_CTRL)) begin
      alt_next = reg_wdata_i[ALT_SEL_BIT];
    end
    // arm when the energy flag is released while energy is still on the line
    armed_next  = armed_reg;
    pulse_start = 1'b0;
    if (mask_reg[SRC_ENERGY] && flags_reg[SRC_ENERGY] && !flags_next[SRC_ENERGY] &&
        line_energy_present_i) begin
      armed_next = 1'b1;
    end
    if (armed_reg && fall_ev[SRC_ENERGY]) begin
      pulse_start = 1'b1;
      armed_next  = 1'b0;
    end
    if (!mask_reg[SRC_ENERGY]) begin
      armed_next = 1'b0;
    end
    pulse_abort = !mask_reg[SRC_ENERGY];
    irq_next = ~(|(flags_reg & mask_reg) || pulse_busy);
    rdata_next = reg_rdata_o;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_IRQ_FLAGS: rdata_next = flags_reg;
        ADDR_IRQ_MASK:  rdata_next = mask_reg;
        ADDR_MODE_CTRL: rdata_next = 16'(alt_irq_scheme_sel_o) << ALT_SEL_BIT;
        default:        rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      flags_reg            <= FLAGS_RESET;
      mask_reg             <= MASK_RESET;
      alt_irq_scheme_sel_o <= 1'b0;
      act_prev_reg         <= ACT_PREV_RESET;
      armed_reg            <= 1'b0;
      irq_out_low_o        <= 1'b1;
      reg_rdata_o          <= 16'h0000;
    end else begin
      flags_reg            <= flags_next;
      mask_reg             <= mask_next;
      alt_irq_scheme_sel_o <= alt_next;
      act_prev_reg         <= act;
      armed_reg            <= armed_next;
      irq_out_low_o        <= irq_next;
      reg_rdata_o          <= rdata_next;
    end
  end

  // holds the interrupt low through the energy-loss pulse
  pim_pulse_timer #(
    .CNT_W  (PULSE_CNT_W),
    .CYCLES (ENERGY_PULSE_CYCLES)
  ) pim_pulse_timer_inst (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .start_i  (pulse_start),
    .abort_i  (pulse_abort),
    .busy_o   (pulse_busy)
  );

  property p_irq_gate;
    @(posedge mclk_i) disable iff (!resetn_i)
    ((flags_reg & mask_reg) != 16'h0000) |=> !irq_out_low_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not low with enabled flag");

  property p_irq_idle;
    @(posedge mclk_i) disable iff (!resetn_i)
    ((flags_reg & mask_reg) == 16'h0000 && !pulse_busy) |=> irq_out_low_o;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq low with nothing pending");

  property p_reset_primary;
    @(posedge mclk_i) disable iff (!resetn_i)
    $past(!resetn_i) |-> (!alt_irq_scheme_sel_o && flags_reg == FLAGS_RESET &&
                          mask_reg == MASK_RESET);
  endproperty
  a_reset_primary: assert property (p_reset_primary) else $error("bad reset state");

  property p_assert_event;
    @(posedge mclk_i) disable iff (!resetn_i)
    (mask_reg[SRC_AN_DONE] && !an_complete_i ##1 an_complete_i && mask_reg[SRC_AN_DONE])
      |=> flags_reg[SRC_AN_DONE] ##1 !irq_out_low_o;
  endproperty
  a_assert_event: assert property (p_assert_event) else $error("event missed");

  property p_read_clears;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!alt_irq_scheme_sel_o && rd_flags && set_ev == 8'h00) |=> flags_reg == 16'h0000;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag read did not clear");

  property p_link_holds;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!alt_irq_scheme_sel_o && flags_reg[SRC_LINK_DOWN] && !reg_rd_i) |=> flags_reg[SRC_LINK_DOWN];
  endproperty
  a_link_holds: assert property (p_link_holds) else $error("link down flag lost");

  property p_restart_clears;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!alt_irq_scheme_sel_o && an_restart_i && !set_ev[SRC_PAR_FAULT]) |=> !flags_reg[SRC_PAR_FAULT];
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart kept fault");

  property p_alt_recheck;
    @(posedge mclk_i) disable iff (!resetn_i)
    (alt_irq_scheme_sel_o && hit(reg_wr_i, reg_addr_i, ADDR_IRQ_FLAGS) && flags_reg[SRC_ENERGY] &&
     reg_wdata_i[SRC_ENERGY]) |=> (flags_reg[SRC_ENERGY] == $past(line_energy_present_i));
  endproperty
  a_alt_recheck: assert property (p_alt_recheck) else $error("recheck wrong");

  property p_alt_no_edge_clear;
    @(posedge mclk_i) disable iff (!resetn_i)
    (alt_irq_scheme_sel_o && flags_reg[SRC_AN_DONE] && !reg_wr_i) |=> flags_reg[SRC_AN_DONE];
  endproperty
  a_alt_no_edge_clear: assert property (p_alt_no_edge_clear)
    else $error("alt flag self cleared");

  property p_mask_release;
    @(posedge mclk_i) disable iff (!resetn_i)
    (mask_reg == 16'h0000 && !pulse_busy) |=> irq_out_low_o;
  endproperty
  a_mask_release: assert property (p_mask_release) else $error("masked irq still low");

  property p_reserved_zero;
    @(posedge mclk_i) disable iff (!resetn_i)
    ((mask_reg | flags_reg) & ~SRC_VALID_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

  property p_energy_pulse;
    @(posedge mclk_i) disable iff (!resetn_i)
    (armed_reg && fall_ev[SRC_ENERGY] && mask_reg[SRC_ENERGY]) |=> pulse_busy ##1 !irq_out_low_o;
  endproperty
  a_energy_pulse: assert property (p_energy_pulse) else $error("energy pulse missing");

  c_alt_clear: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    alt_irq_scheme_sel_o && hit(reg_wr_i, reg_addr_i, ADDR_IRQ_FLAGS) && clr != 8'h00);
  c_pulse: cover property (@(posedge mclk_i) disable iff (!resetn_i) pulse_start);
  c_link_irq: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    set_ev[SRC_LINK_DOWN] && mask_reg[SRC_LINK_DOWN]);
  c_energy_arm: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    armed_next && !armed_reg);
  c_alt_keep: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    alt_irq_scheme_sel_o && hit(reg_wr_i, reg_addr_i, ADDR_IRQ_FLAGS) && clr == 8'h00);

  property p_status_read_clears;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!alt_irq_scheme_sel_o && rd_status && !set_ev[SRC_REM_FAULT])
      |=> !flags_reg[SRC_REM_FAULT];
  endproperty
  a_status_read_clears: assert property (p_status_read_clears)
    else $error("status read kept fault");

  property p_link_loss_clears;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!alt_irq_scheme_sel_o && (rd_expan || set_ev[SRC_LINK_DOWN]) && !set_ev[SRC_PAGE_RX])
      |=> !flags_reg[SRC_PAGE_RX];
  endproperty
  a_link_loss_clears: assert property (p_link_loss_clears)
    else $error("page flag kept");

  // a flag write in the primary scheme must never release anything
  property p_primary_wr_ignored;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!alt_irq_scheme_sel_o && hit(reg_wr_i, reg_addr_i, ADDR_IRQ_FLAGS) && !reg_rd_i &&
     fall_ev == 8'h00 && !an_restart_i && !set_ev[SRC_LINK_DOWN])
      |=> (flags_reg & $past(flags_reg)) == $past(flags_reg);
  endproperty
  a_primary_wr_ignored: assert property (p_primary_wr_ignored)
    else $error("flag write acted in primary scheme");

  property p_event_latches;
    @(posedge mclk_i) disable iff (!resetn_i)
    (set_ev != 8'h00) |=> (flags_reg[7:0] & $past(set_ev)) == $past(set_ev);
  endproperty
  a_event_latches: assert property (p_event_latches)
    else $error("event not latched");

  property p_scheme_holds;
    @(posedge mclk_i) disable iff (!resetn_i)
    !hit(reg_wr_i, reg_addr_i, ADDR_MODE_CTRL)
      |=> alt_irq_scheme_sel_o == $past(alt_irq_scheme_sel_o);
  endproperty
  a_scheme_holds: assert property (p_scheme_holds)
    else $error("scheme changed without a write");
endmodule : pim_irq_ctrl
`default_nettype wire

// [pim_pkg.sv]
`default_nettype none
package pim_pkg;
  localparam int          REG_ADDR_W        = 5;
  localparam int          REG_DATA_W        = 16;
  // management register addresses touched by this block
  localparam logic [4:0]  ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0]  ADDR_AN_EXPANSION = 5'h06;
  localparam logic [4:0]  ADDR_MODE_CTRL    = 5'h11;
  localparam logic [4:0]  ADDR_IRQ_FLAGS    = 5'h1D;
  localparam logic [4:0]  ADDR_IRQ_MASK     = 5'h1E;
  // source bit positions, shared by flag and mask registers
  localparam int          SRC_ENERGY        = 7;
  localparam int          SRC_AN_DONE       = 6;
  localparam int          SRC_REM_FAULT     = 5;
  localparam int          SRC_LINK_DOWN     = 4;
  localparam int          SRC_LP_ACK        = 3;
  localparam int          SRC_PAR_FAULT     = 2;
  localparam int          SRC_PAGE_RX       = 1;
  localparam int          ALT_SEL_BIT       = 6;
  localparam logic [15:0] SRC_VALID_MASK    = 16'h00FE;
  localparam logic [15:0] FLAGS_RESET       = 16'h0080;
  localparam logic [15:0] MASK_RESET        = 16'h0000;
  localparam logic [7:0]  ACT_PREV_RESET    = 8'h80;
  // energy-loss pulse length
  localparam int          CLK_HZ            = 100_000_000;
  localparam int          ENERGY_PULSE_MS   = 256;
  localparam int          ENERGY_PULSE_CYC  = ENERGY_PULSE_MS * (CLK_HZ / 1000);
  localparam int          PULSE_CNT_W       = 25;
endpackage : pim_pkg
`default_nettype wire

// [pim_pulse_timer.sv]
`default_nettype none
module pim_pulse_timer
  import pim_pkg::*;
#(
  parameter int CNT_W  = PULSE_CNT_W,
  parameter int CYCLES = ENERGY_PULSE_CYC
) (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  input  wire logic abort_i,
  output logic      busy_o
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             busy_next;

  always_comb begin
    cnt_next  = cnt_reg;
    busy_next = busy_o;
    if (abort_i) begin
      cnt_next  = '0;
      busy_next = 1'b0;
    end else if (start_i) begin
      cnt_next  = CNT_W'(CYCLES - 1);
      busy_next = 1'b1;
    end else if (busy_o) begin
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
      busy_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_o  <= busy_next;
    end
  end
endmodule : pim_pulse_timer
`default_nettype wire
